// File: hw/cmp_defines.svh
`ifndef CMP_DEFINES_SVH
`define CMP_DEFINES_SVH

// register byte offsets on the apb window
`define CMP_OFS_CTRL 8'h00
`define CMP_OFS_PAD 8'h04
`define CMP_OFS_PRIM 8'h08
`define CMP_OFS_SEC 8'h0c
`define CMP_OFS_STAT 8'h10
`define CMP_OFS_TB2_CTRL 8'h14
`define CMP_OFS_TB2_PER 8'h18
`define CMP_OFS_TB2_CNT 8'h1c
`define CMP_OFS_TB3_CTRL 8'h20
`define CMP_OFS_TB3_PER 8'h24
`define CMP_OFS_TB3_CNT 8'h28

// field positions
`define CMP_BIT_IDLE 13
`define CMP_BIT_FAULT 4
`define CMP_BIT_TBSEL 3
`define CMP_MODE_HI 2
`define CMP_MODE_LO 0
`define CMP_BIT_PADDIS 3
`define CMP_BIT_TBON 15
`define CMP_BIT_IRQ 0

// reset values
`define CMP_RST_BIT 1'h0
`define CMP_RST_WORD 32'h0000_0000

`endif

// File: hw/cmp_pkg.sv
package cmp_pkg;

    // channel mode codes as software writes them
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_SET_HIGH = 3'h1,
        MODE_SET_LOW = 3'h2,
        MODE_TOGGLE = 3'h3,
        MODE_ONE_PULSE = 3'h4,
        MODE_PULSE_TRAIN = 3'h5,
        MODE_PWM = 3'h6,
        MODE_PWM_FAULT = 3'h7
    } compare_mode_sel_t;

    // pulse sequencer, gray along rise -> fall -> done
    typedef enum logic [1:0] {
        PS_WAIT_RISE = 2'h0,
        PS_WAIT_FALL = 2'h1,
        PS_DONE = 2'h3
    } pulse_state_t;

endpackage

// File: hw/cmp_timebase.sv
`timescale 1ns/100ps
`include "cmp_defines.svh"

module cmp_timebase #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control and software writes
    input wire logic on_in,
    input wire logic cnt_wr_in,
    input wire logic per_wr_in,
    input wire logic [W-1:0] wdata_in,
    // state
    output logic [W-1:0] count_out,
    output logic [W-1:0] period_out
);
    typedef struct packed {
        logic [W-1:0] count;
        logic [W-1:0] period;
    } tb_state_t;

    tb_state_t st_q;
    tb_state_t st_d;

    // the logic handles widths from 2 to 16 bits only
    if (W < 2 || W > 16) begin : g_bad_width
        $error("cmp_timebase: width out of range");
    end

    // count up, wrap to zero on the period match
    always_comb begin
        st_d = st_q;
        if (cnt_wr_in) begin
            st_d.count = wdata_in;
        end else if (on_in) begin
            if (st_q.count == st_q.period) begin
                st_d.count = '0;
            end else begin
                st_d.count = st_q.count + W'(1);
            end
        end
        if (per_wr_in) begin
            st_d.period = wdata_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_out = st_q.count;
    assign period_out = st_q.period;

    AST_TB_WRAP: assert property (@(posedge clk_in) disable iff (rst_in)
        (on_in && !cnt_wr_in && count_out == period_out) |=> count_out == '0)
        else $error("time base did not wrap on period match");

endmodule

// File: hw/output_compare_pwm_channel.sv
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "cmp_defines.svh"
//
// Contract
// - continuous pulse mode starts low, pulses every period
// - pulse modes rise on primary match
// - pulse modes fall on secondary match
// - continuous pulses set flag on secondary match
// - time base wraps to zero at period
// - rise, fall, wrap repeat without end
// - primary compare read-only in pwm modes
// - duty copied to primary at period match
// - primary value at start sets first duty
// - period N gives N plus one counts
// - duty zero holds output low
// - duty above period holds output high
// - duty equal period: low one count
// - mode codes off, set, clear, toggle, single
// - codes 110/111 pwm without/with fault input
// - fault status set by fault, cleared by a control register write
// - time base select picks third or second timer
// - idle halt bit stops channel in idle
// - pad disable keeps output off the pin
// - secondary writable anytime without period disturbance
// - single pulse stays low until mode rewritten

module output_compare_pwm_channel
    import cmp_pkg::*;
#(
    parameter int W = 16
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // apb slave
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // processor idle state, same clock domain
    input wire logic IDLE_IN,
    // fault input pin, asynchronous
    input wire logic FAULT_INPUT_PIN_IN,
    // compare output pin and internal trigger
    output logic COMPARE_OUT_PIN_OUT,
    output logic COMPARE_OUT_PIN_OE_OUT,
    output logic TRIGGER_OUT,
    // compare event flag
    output logic COMPARE_IRQ_FLAG_OUT
);
    typedef struct packed {
        compare_mode_sel_t mode;
        logic idle_halt;
        logic tb_sel;
        logic fault;
        logic pad_dis;
        logic [W-1:0] prim;
        logic [W-1:0] sec;
        logic irq;
        pulse_state_t pst;
        logic out;
        logic oe;
        logic pin;
        logic flt_meta;
        logic flt_sync;
        logic tb2_on;
        logic tb3_on;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } chan_state_t;

    chan_state_t st_q;
    chan_state_t st_d;

    if (W < 2 || W > 16) begin : g_bad_width
        $error("output_compare_pwm_channel: width out of range");
    end

    logic [W-1:0] cnt2;
    logic [W-1:0] per2;
    logic [W-1:0] cnt3;
    logic [W-1:0] per3;
    logic [W-1:0] cnt;
    logic [W-1:0] per;
    logic [W-1:0] wdata;
    logic access;
    logic wr;
    logic halt;
    logic is_pwm;
    logic match_p;
    logic match_s;
    logic match_per;
    logic fault_evt;

    // address match, used by every write strobe; the read mux decodes PADDR in a case
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // pad a register field into the bus word, upper bits read zero
    function automatic logic [31:0] word(input logic [W-1:0] v);
        return {{(32 - W){1'b0}}, v};
    endfunction

    function automatic logic is_pwm_mode(input compare_mode_sel_t m);
        return m == MODE_PWM || m == MODE_PWM_FAULT;
    endfunction

    // a write takes effect only at the edge that completes the access
    assign access = PSEL & PENABLE & st_q.pready;
    assign wr = access & PWRITE;
    assign wdata = PWDATA[W-1:0];

    // the two time bases the channel can follow
    cmp_timebase #(.W(W)) u_tb2 (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .on_in(st_q.tb2_on),
        .cnt_wr_in(wr && hit(PADDR, `CMP_OFS_TB2_CNT)),
        .per_wr_in(wr && hit(PADDR, `CMP_OFS_TB2_PER)),
        .wdata_in(wdata),
        .count_out(cnt2),
        .period_out(per2)
    );

    cmp_timebase #(.W(W)) u_tb3 (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .on_in(st_q.tb3_on),
        .cnt_wr_in(wr && hit(PADDR, `CMP_OFS_TB3_CNT)),
        .per_wr_in(wr && hit(PADDR, `CMP_OFS_TB3_PER)),
        .wdata_in(wdata),
        .count_out(cnt3),
        .period_out(per3)
    );

    // selected time base and the three match terms
    always_comb begin
        cnt = st_q.tb_sel ? cnt3 : cnt2;
        per = st_q.tb_sel ? per3 : per2;
        halt = st_q.idle_halt & IDLE_IN;
        is_pwm = is_pwm_mode(st_q.mode);
        match_p = cnt == st_q.prim;
        match_s = cnt == st_q.sec;
        match_per = cnt == per;
        fault_evt = (st_q.mode == MODE_PWM_FAULT) & st_q.flt_sync & ~halt;
    end

    // channel behaviour, then software writes, then sticky sets
    always_comb begin
        st_d = st_q;
        // fault pin passes two flops before anything looks at it
        st_d.flt_meta = FAULT_INPUT_PIN_IN;
        st_d.flt_sync = st_q.flt_meta;

        if (!halt) begin
            case (st_q.mode)
                MODE_OFF: st_d.out = 1'b0;
                MODE_SET_HIGH: begin
                    if (match_p) begin
                        st_d.out = 1'b1;
                    end
                end
                MODE_SET_LOW: begin
                    if (match_p) begin
                        st_d.out = 1'b0;
                    end
                end
                MODE_TOGGLE: begin
                    if (match_p) begin
                        st_d.out = ~st_q.out;
                    end
                end
                MODE_ONE_PULSE, MODE_PULSE_TRAIN: begin
                    case (st_q.pst)
                        PS_WAIT_RISE: begin
                            if (match_p) begin
                                st_d.out = 1'b1;
                                st_d.pst = PS_WAIT_FALL;
                            end
                        end
                        PS_WAIT_FALL: begin
                            if (match_s) begin
                                st_d.out = 1'b0;
                                st_d.irq = 1'b1;
                                // the train re-arms, the single pulse parks
                                st_d.pst = (st_q.mode == MODE_PULSE_TRAIN) ?
                                    PS_WAIT_RISE : PS_DONE;
                            end
                        end
                        PS_DONE: st_d.out = 1'b0;
                        default: st_d.pst = PS_WAIT_RISE;
                    endcase
                end
                default: begin
                    // pwm: level from count against duty, one cycle behind
                    // the count so every count value maps to one output cycle
                    st_d.out = cnt < st_q.prim;
                    if (match_per) begin
                        st_d.prim = st_q.sec;
                    end
                    if (st_q.fault || fault_evt) begin
                        st_d.out = 1'b0;
                    end
                end
            endcase
        end

        if (wr) begin
            if (hit(PADDR, `CMP_OFS_CTRL)) begin
                st_d.mode = compare_mode_sel_t'(PWDATA[`CMP_MODE_HI:`CMP_MODE_LO]);
                st_d.idle_halt = PWDATA[`CMP_BIT_IDLE];
                st_d.tb_sel = PWDATA[`CMP_BIT_TBSEL];
                st_d.fault = 1'b0;
                st_d.pst = PS_WAIT_RISE;
                // each mode write re-initialises the pin
                st_d.out = compare_mode_sel_t'(PWDATA[`CMP_MODE_HI:`CMP_MODE_LO])
                    == MODE_SET_LOW;
            end
            if (hit(PADDR, `CMP_OFS_PAD)) begin
                st_d.pad_dis = PWDATA[`CMP_BIT_PADDIS];
            end
            if (hit(PADDR, `CMP_OFS_PRIM) && !is_pwm) begin
                st_d.prim = wdata;
            end
            if (hit(PADDR, `CMP_OFS_SEC)) begin
                st_d.sec = wdata;
            end
            if (hit(PADDR, `CMP_OFS_STAT) && PWDATA[`CMP_BIT_IRQ]) begin
                st_d.irq = 1'b0;
            end
            if (hit(PADDR, `CMP_OFS_TB2_CTRL)) begin
                st_d.tb2_on = PWDATA[`CMP_BIT_TBON];
            end
            if (hit(PADDR, `CMP_OFS_TB3_CTRL)) begin
                st_d.tb3_on = PWDATA[`CMP_BIT_TBON];
            end
        end

        // hardware sets win over a clear in the same cycle
        if (fault_evt) begin
            st_d.fault = 1'b1;
        end
        if (!halt && match_s && st_q.pst == PS_WAIT_FALL &&
            (st_q.mode == MODE_ONE_PULSE || st_q.mode == MODE_PULSE_TRAIN)) begin
            st_d.irq = 1'b1;
        end

        st_d.oe = ~st_d.pad_dis;
        // pin value gets its own flop so the port has no gate behind it
        st_d.pin = st_d.out & st_d.oe;

        // apb answers in the first access cycle, no wait states
        st_d.pready = PSEL & ~PENABLE;
        st_d.pslverr = 1'b0;
        st_d.prdata = `CMP_RST_WORD;
        if (PSEL && !PENABLE) begin
            case (PADDR)
                `CMP_OFS_CTRL: begin
                    st_d.prdata[`CMP_MODE_HI:`CMP_MODE_LO] = st_q.mode;
                    st_d.prdata[`CMP_BIT_IDLE] = st_q.idle_halt;
                    st_d.prdata[`CMP_BIT_TBSEL] = st_q.tb_sel;
                    st_d.prdata[`CMP_BIT_FAULT] = st_q.fault;
                end
                `CMP_OFS_PAD: st_d.prdata[`CMP_BIT_PADDIS] = st_q.pad_dis;
                `CMP_OFS_PRIM: st_d.prdata = word(st_q.prim);
                `CMP_OFS_SEC: st_d.prdata = word(st_q.sec);
                `CMP_OFS_STAT: st_d.prdata[`CMP_BIT_IRQ] = st_q.irq;
                `CMP_OFS_TB2_CTRL: st_d.prdata[`CMP_BIT_TBON] = st_q.tb2_on;
                `CMP_OFS_TB2_PER: st_d.prdata = word(per2);
                `CMP_OFS_TB2_CNT: st_d.prdata = word(cnt2);
                `CMP_OFS_TB3_CTRL: st_d.prdata[`CMP_BIT_TBON] = st_q.tb3_on;
                `CMP_OFS_TB3_PER: st_d.prdata = word(per3);
                `CMP_OFS_TB3_CNT: st_d.prdata = word(cnt3);
                default: st_d.pslverr = 1'b1; // unmapped, write already ignored
            endcase
        end
    end

    // all channel state in one register
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            st_q <= '0;
            st_q.oe <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign PRDATA = st_q.prdata;
    assign PREADY = st_q.pready;
    assign PSLVERR = st_q.pslverr;
    assign COMPARE_OUT_PIN_OUT = st_q.pin; // pin parked low when disabled
    assign COMPARE_OUT_PIN_OE_OUT = st_q.oe;
    assign TRIGGER_OUT = st_q.out; // still usable inside with the pad off
    assign COMPARE_IRQ_FLAG_OUT = st_q.irq;

    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    logic ctl_wr;
    assign ctl_wr = wr && hit(PADDR, `CMP_OFS_CTRL);

    AST_TRAIN_START_LOW: assert property (
        (ctl_wr && PWDATA[`CMP_MODE_HI:`CMP_MODE_LO] == MODE_PULSE_TRAIN)
        |=> !st_q.out && st_q.pst == PS_WAIT_RISE)
        else $error("continuous pulse mode did not start low");

    AST_PULSE_RISE: assert property (
        (!halt && !wr && st_q.pst == PS_WAIT_RISE && match_p &&
         (st_q.mode == MODE_ONE_PULSE || st_q.mode == MODE_PULSE_TRAIN))
        |=> st_q.out)
        else $error("pulse did not rise on primary match");

    AST_PULSE_FALL_FLAG: assert property (
        (!halt && !ctl_wr && st_q.pst == PS_WAIT_FALL && match_s &&
         (st_q.mode == MODE_ONE_PULSE || st_q.mode == MODE_PULSE_TRAIN))
        |=> st_q.irq && !st_q.out)
        else $error("pulse did not fall with flag on secondary match");

    AST_DUTY_LOCKED: assert property (
        (is_pwm && wr && hit(PADDR, `CMP_OFS_PRIM) && !match_per && !ctl_wr)
        |=> $stable(st_q.prim))
        else $error("primary compare changed by a write in pwm mode");

    AST_DUTY_RELOAD: assert property (
        (is_pwm && !halt && match_per && !wr) |=> st_q.prim == $past(st_q.sec))
        else $error("duty not reloaded at period match");

    AST_PWM_ZERO: assert property (
        (is_pwm && !halt && !ctl_wr && st_q.prim == '0) |=> !st_q.out)
        else $error("zero duty drove output high");

    AST_PWM_FULL: assert property (
        (st_q.mode == MODE_PWM && !halt && st_q.prim > per && !wr) |=> st_q.out)
        else $error("duty above period did not hold output high");

    AST_SINGLE_PARKS: assert property (
        (st_q.mode == MODE_ONE_PULSE && st_q.pst == PS_DONE && !ctl_wr)
        |=> st_q.pst == PS_DONE && !st_q.out)
        else $error("single pulse restarted without a mode write");

    AST_FAULT_FORCE: assert property (
        (fault_evt && !ctl_wr) |=> st_q.fault && !st_q.out)
        else $error("fault did not force output low and latch status");

    AST_FAULT_STICKY: assert property (
        (st_q.fault && !ctl_wr) |=> st_q.fault)
        else $error("fault status cleared without a mode write");

    AST_IDLE_HALT: assert property (
        (halt && !wr) |=> $stable(st_q.out) && $stable(st_q.pst))
        else $error("channel moved while halted in idle");

    AST_PAD_DISABLE: assert property (
        (wr && hit(PADDR, `CMP_OFS_PAD))
        |=> COMPARE_OUT_PIN_OE_OUT == !$past(PWDATA[`CMP_BIT_PADDIS]))
        else $error("pad output enable does not follow disable bit");

endmodule

// File: test/pin_load_model.sv
`timescale 1ns/100ps
module pin_load_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // pin as the channel drives it
    input wire logic pin_in,
    input wire logic oe_in,
    // pad level and accumulated high time
    output logic pad_out,
    output logic [31:0] high_cycles_out
);
    // pull-down holds the pad low once the channel lets go of it
    assign pad_out = oe_in ? pin_in : 1'b0;
    // running high time, so duty can be read over any window
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            high_cycles_out <= 32'h0;
        end else begin
            high_cycles_out <= high_cycles_out + {31'h0, pad_out};
        end
    end
endmodule

// File: test/tb_output_compare_pwm_channel.sv
`timescale 1ns/100ps
`include "cmp_defines.svh"
module tb_output_compare_pwm_channel;
    import cmp_pkg::*;
    typedef struct packed {logic rd; logic err; logic [31:0] d;} note_t;
    logic CLK_IN = 1'b0;
    logic RST_IN = 1'b1;
    logic [7:0] PADDR = 8'h0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [31:0] PWDATA = 32'h0;
    logic IDLE_IN = 1'b0;
    logic FAULT_IN = 1'b0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, PIN, OE, TRIGGER_OUT, FLAG, pad;
    logic [31:0] hc;
    note_t notes[$];
    note_t nt;
    int n_fail = 0;
    int checked = 0;
    logic [31:0] lfsr = 32'hd9eea4bd;

    always #20 CLK_IN = ~CLK_IN;

    output_compare_pwm_channel #(.W(16)) dut_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
        .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IDLE_IN(IDLE_IN),
        .FAULT_INPUT_PIN_IN(FAULT_IN), .COMPARE_OUT_PIN_OUT(PIN),
        .COMPARE_OUT_PIN_OE_OUT(OE), .TRIGGER_OUT(TRIGGER_OUT), .COMPARE_IRQ_FLAG_OUT(FLAG));
    pin_load_model load_u (.clk_in(CLK_IN), .rst_in(RST_IN), .pin_in(PIN), .oe_in(OE),
        .pad_out(pad), .high_cycles_out(hc));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // simple feedback shift for duty values
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // one apb transfer; the monitor below compares the answer
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic err);
        int i;
        @(posedge CLK_IN);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        notes.push_back('{~w, err, e});
        @(posedge CLK_IN);
        PENABLE <= 1'b1;
        // request stands until pready is seen high at a rising edge
        for (i = 0; i < 16; i++) begin
            @(posedge CLK_IN);
            if (PREADY === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            print_verdict();
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b0);
    endtask

    // high time of trigger (own samples) and of pad (load) over n cycles
    task automatic cnt(input int n, output logic [31:0] hi, output logic [31:0] hp);
        logic [31:0] h0;
        @(negedge CLK_IN);
        h0 = hc;
        hi = 32'h0;
        repeat (n) begin
            @(negedge CLK_IN);
            hi = hi + {31'h0, TRIGGER_OUT};
        end
        hp = hc - h0;
    endtask

    // cycles from one rising edge of the trigger to the next
    task automatic per(output logic [31:0] p);
        logic prev;
        int r;
        p = 32'h0;
        prev = 1'b1;
        r = 0;
        for (int i = 0; i < 200 && r < 2; i++) begin
            @(negedge CLK_IN);
            if (r > 0) p++;
            if (prev === 1'b0 && TRIGGER_OUT === 1'b1) r++;
            prev = TRIGGER_OUT;
        end
    endtask

    task automatic pin_is(input int wait_n, input logic e);
        repeat (wait_n) @(posedge CLK_IN);
        @(negedge CLK_IN);
        chk("pin level", {31'h0, e}, {31'h0, PIN});
    endtask

    // answer monitor: oldest note against what the slave returns
    always @(posedge CLK_IN) begin
        if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1) begin
            nt = notes.pop_front();
            chk("slave error", {31'h0, nt.err}, {31'h0, PSLVERR});
            if (nt.rd) chk("read data", nt.d, PRDATA);
        end
    end

    initial begin
        logic [31:0] hi, hp, d;
        repeat (4) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        rd(`CMP_OFS_CTRL, 32'h0);
        rd(`CMP_OFS_PAD, 32'h0);
        apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h44, 32'h5, 32'h0, 1'b1);
        // pwm, period 7, first duty from primary
        wr(`CMP_OFS_TB2_PER, 32'h7);
        wr(`CMP_OFS_SEC, 32'h3);
        wr(`CMP_OFS_PRIM, 32'h3);
        wr(`CMP_OFS_CTRL, 32'h6);
        wr(`CMP_OFS_TB2_CTRL, 32'h8000);
        wr(`CMP_OFS_PRIM, 32'h6);
        rd(`CMP_OFS_PRIM, 32'h3);
        cnt(8, hi, hp);
        chk("first duty", 32'h3, hi);
        per(hi);
        chk("pwm period", 32'h8, hi);
        // boundary duties first, then random ones
        for (int k = 0; k < 6; k++) begin
            d = (k == 0) ? 32'h0 : (k == 1) ? 32'h9 : (k == 2) ? 32'h7 : {29'h0, lfsr[2:0]};
            lfsr = next_rand(lfsr);
            wr(`CMP_OFS_SEC, d);
            repeat (20) @(posedge CLK_IN);
            cnt(8, hi, hp);
            chk("pwm duty", (d > 7) ? 32'h8 : d, hi);
            chk("pad duty", (d > 7) ? 32'h8 : d, hp);
            rd(`CMP_OFS_PRIM, d);
        end
        wr(`CMP_OFS_SEC, 32'h3);
        wr(`CMP_OFS_PAD, 32'h8);
        rd(`CMP_OFS_PAD, 32'h8);
        repeat (20) @(posedge CLK_IN);
        cnt(8, hi, hp);
        chk("trigger duty", 32'h3, hi);
        chk("pad duty", 32'h0, hp);
        chk("pin enable", 32'h0, {31'h0, OE});
        wr(`CMP_OFS_PAD, 32'h0);
        // idle halt set freezes the channel, clear keeps it running
        wr(`CMP_OFS_CTRL, 32'h2006);
        IDLE_IN <= 1'b1;
        repeat (3) @(posedge CLK_IN);
        cnt(8, hi, hp);
        chk("idle frozen", 32'h1, {31'h0, hi == 0 || hi == 8});
        IDLE_IN <= 1'b0;
        wr(`CMP_OFS_CTRL, 32'h6);
        IDLE_IN <= 1'b1;
        repeat (20) @(posedge CLK_IN);
        cnt(8, hi, hp);
        chk("idle running", 32'h3, hi);
        IDLE_IN <= 1'b0;
        // fault in mode 111 forces low and latches status
        wr(`CMP_OFS_CTRL, 32'h7);
        FAULT_IN <= 1'b1;
        repeat (6) @(posedge CLK_IN);
        cnt(8, hi, hp);
        chk("fault output", 32'h0, hi);
        rd(`CMP_OFS_CTRL, 32'h17);
        FAULT_IN <= 1'b0;
        wr(`CMP_OFS_CTRL, 32'h7);
        rd(`CMP_OFS_CTRL, 32'h7);
        wr(`CMP_OFS_CTRL, 32'h6);
        FAULT_IN <= 1'b1;
        repeat (20) @(posedge CLK_IN);
        cnt(8, hi, hp);
        chk("fault ignored", 32'h3, hi);
        rd(`CMP_OFS_CTRL, 32'h6);
        FAULT_IN <= 1'b0;
        // plain compare modes on the third timer, still stopped
        wr(`CMP_OFS_CTRL, 32'h0);
        cnt(10, hi, hp);
        chk("off output", 32'h0, hi);
        wr(`CMP_OFS_PRIM, 32'h2);
        rd(`CMP_OFS_PRIM, 32'h2);
        wr(`CMP_OFS_SEC, 32'h5);
        wr(`CMP_OFS_TB3_PER, 32'h9);
        wr(`CMP_OFS_CTRL, 32'ha);
        pin_is(3, 1'b1);
        wr(`CMP_OFS_CTRL, 32'hd);
        pin_is(3, 1'b0);
        wr(`CMP_OFS_CTRL, 32'h9);
        wr(`CMP_OFS_TB3_CTRL, 32'h8000);
        pin_is(12, 1'b1);
        wr(`CMP_OFS_CTRL, 32'ha);
        pin_is(12, 1'b0);
        wr(`CMP_OFS_CTRL, 32'hb);
        repeat (12) @(posedge CLK_IN);
        cnt(20, hi, hp);
        chk("toggle duty", 32'ha, hi);
        // continuous pulses
        wr(`CMP_OFS_STAT, 32'h1);
        wr(`CMP_OFS_CTRL, 32'hd);
        repeat (12) @(posedge CLK_IN);
        per(hi);
        chk("pulse period", 32'ha, hi);
        cnt(10, hi, hp);
        chk("pulse width", 32'h3, hi);
        rd(`CMP_OFS_STAT, 32'h1);
        chk("flag pin", 32'h1, {31'h0, FLAG});
        wr(`CMP_OFS_STAT, 32'h1);
        repeat (12) @(posedge CLK_IN);
        rd(`CMP_OFS_STAT, 32'h1);
        // single pulse parks low until rearmed
        wr(`CMP_OFS_CTRL, 32'hc);
        repeat (14) @(posedge CLK_IN);
        cnt(20, hi, hp);
        chk("single parked", 32'h0, hi);
        wr(`CMP_OFS_CTRL, 32'hc);
        cnt(25, hi, hp);
        chk("single rearmed", 32'h3, hi);
        print_verdict();
    end
endmodule
